//--- cce_pkg.sv
// Constants, opcodes and carrier types for the compare/clear/BCD/divide execution unit.
// Assumes an 8-bit accumulator core whose sequencer hands in fetched operands.
//
// Functional notes
// RL1 - Compare-and-jump branches only when the two operands differ, else falls through.
// RL2 - Branch target is PC plus three plus the signed last instruction byte.
// RL3 - Compare sets carry when first operand is unsigned-less than second; operands unchanged.
// RL4 - Compare pairs: A/direct, A/immediate, register/immediate, indirect/immediate, own opcodes.
// RL5 - Clear accumulator zeroes all eight bits in one cycle, flags untouched.
// RL6 - Bit clear zeroes carry or an addressed bit, each by own opcode.
// RL7 - Complement accumulator inverts every bit in one cycle, flags untouched.
// RL8 - Bit complement inverts carry or an addressed bit, own opcodes, no other flags.
// RL9 - Port read-modify-write takes the original value from the output latch, not pins.
// RL10 - Decimal adjust adds six when low nibble above nine or aux carry; only sets carry.
// RL11 - Then adds sixty when carry set or high nibble above nine; only sets carry.
// RL12 - Decimal adjust completes in one cycle and leaves overflow unchanged.
// RL13 - Decrement subtracts one, zero wraps to all ones, no flags change.
// RL14 - Decrement targets accumulator, register, direct byte or indirect location, own opcodes.
// RL15 - Divide gives quotient to accumulator, remainder to auxiliary register, clears carry, overflow.
// RL16 - Zero divisor sets overflow and clears carry; results undefined.
// RL17 - Additions set aux carry from bit 3 and carry from bit 7.
// RL18 - Flag updates reach the status word in the same instruction.

package cce_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_CMP_A_IMM   = 8'hB4;
  localparam logic [7:0] OP_CMP_A_DIR   = 8'hB5;
  localparam logic [7:0] OP_CMP_IND     = 8'hB6;
  localparam logic [7:0] OP_CMP_REG     = 8'hB8;
  localparam logic [7:0] OP_CLR_A       = 8'hE4;
  localparam logic [7:0] OP_CLR_C       = 8'hC3;
  localparam logic [7:0] OP_CLR_BIT     = 8'hC2;
  localparam logic [7:0] OP_CPL_A       = 8'hF4;
  localparam logic [7:0] OP_CPL_C       = 8'hB3;
  localparam logic [7:0] OP_CPL_BIT     = 8'hB2;
  localparam logic [7:0] OP_DEC_ADJ     = 8'hD4;
  localparam logic [7:0] OP_DEC_A       = 8'h14;
  localparam logic [7:0] OP_DEC_DIR     = 8'h15;
  localparam logic [7:0] OP_DEC_IND     = 8'h16;
  localparam logic [7:0] OP_DEC_REG     = 8'h18;
  localparam logic [7:0] OP_DIV         = 8'h84;
  localparam logic [7:0] OP_ADD_IMM     = 8'h24;
  localparam logic [7:0] OP_ADD_DIR     = 8'h25;
  localparam logic [7:0] OP_ADDC_IMM    = 8'h34;
  localparam logic [7:0] OP_ADDC_DIR    = 8'h35;
  localparam logic [4:0] OP_ADD_HI      = 5'h05;
  localparam logic [4:0] OP_ADDC_HI     = 5'h07;
  localparam logic [6:0] OP_IND_MASK    = 7'h7F;

  // ****************************************
  // Lengths, BCD constants, counts, reset values
  // ****************************************
  localparam logic [1:0] LEN_ONE        = 2'h1;
  localparam logic [1:0] LEN_TWO        = 2'h2;
  localparam logic [1:0] LEN_THREE      = 2'h3;
  localparam logic [3:0] BCD_MAX_DIGIT  = 4'h9;
  localparam logic [8:0] BCD_LOW_FIX    = 9'h006;
  localparam logic [8:0] BCD_HIGH_FIX   = 9'h060;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [7:0] BYTE_ONE       = 8'h01;
  localparam logic [3:0] DIV_STEPS      = 4'h8;
  localparam logic       RST_DONE       = 1'b0;
  localparam logic       RST_BUSY       = 1'b0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01
  } cce_state_type;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  acc;
    logic [7:0]  auxReg;
    logic [7:0]  opByte;
    logic [7:0]  immData;
    logic [7:0]  rel;
    logic [15:0] pc;
    logic        carry;
    logic        auxCarry;
    logic        overflow;
    logic        bitLatch;
    logic        byteIsPort;
    logic [7:0]  portLatch;
  } cce_request_type;

  typedef struct packed {
    logic        accWrite;
    logic [7:0]  accValue;
    logic        auxWrite;
    logic [7:0]  auxValue;
    logic        byteWrite;
    logic [7:0]  byteValue;
    logic        bitWrite;
    logic        bitValue;
    logic        pswWrite;
    logic        carry;
    logic        auxCarry;
    logic        overflow;
    logic        branchTaken;
    logic [15:0] nextPc;
  } cce_result_type;

  localparam cce_result_type RST_RESULT = '0;

endpackage

//--- cce_div_unit.sv
// Iterative restoring 8-by-8 unsigned divider.
// Assumes the caller never starts it with a zero divisor and holds operands while busy.
`timescale 1ns/10ps

module cce_div_unit (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] dividend,
  input  wire logic [7:0] divisor,
  output logic [7:0]      quotient,
  output logic [7:0]      remainder,
  output logic            done
);

  logic [7:0] quo_reg;
  logic [7:0] quo_next;
  logic [7:0] rem_reg;
  logic [7:0] rem_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       done_reg;
  logic       done_next;
  logic [8:0] trial;

  // ****************************************
  // One quotient bit per cycle
  // ****************************************
  always_comb begin
    quo_next  = quo_reg;
    rem_next  = rem_reg;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    trial     = {rem_reg, quo_reg[7]};
    if (start) begin
      quo_next = dividend;
      rem_next = cce_pkg::BYTE_ZERO;
      cnt_next = cce_pkg::DIV_STEPS;
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
      if (trial >= {1'b0, divisor}) begin
        rem_next = 8'(trial - {1'b0, divisor});
        quo_next = {quo_reg[6:0], 1'b1};
      end else begin
        rem_next = trial[7:0];
        quo_next = {quo_reg[6:0], 1'b0};
      end
      done_next = (cnt_reg == 4'h1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      quo_reg  <= 8'h00;
      rem_reg  <= 8'h00;
      cnt_reg  <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      quo_reg  <= quo_next;
      rem_reg  <= rem_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign quotient  = quo_reg;
  assign remainder = rem_reg;
  assign done      = done_reg;

endmodule

//--- cce_exec_unit.sv
// Execution unit for compare-jump, clear, complement, decimal adjust, decrement,
// add flag generation and divide.
// Assumes the sequencer presents a fully fetched request with a one-cycle start
// pulse, only while busy is low, and applies the registered result when done pulses.
`timescale 1ns/10ps

module cce_exec_unit (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     start,
  input  wire cce_pkg::cce_request_type request,
  output cce_pkg::cce_result_type       result,
  output logic                          done,
  output logic                          busy
);

  cce_pkg::cce_state_type  state_reg;
  cce_pkg::cce_state_type  state_next;
  cce_pkg::cce_result_type result_reg;
  cce_pkg::cce_result_type result_next;
  logic                    done_reg;
  logic                    done_next;
  logic                    busy_reg;
  logic                    busy_next;
  cce_pkg::cce_request_type held_reg;
  cce_pkg::cce_request_type held_next;

  logic                    divStart;
  logic [7:0]              divQuotient;
  logic [7:0]              divRemainder;
  logic                    divDone;

  logic [7:0]              op;
  logic                    isCmp;
  logic                    isDec;
  logic                    isAdd;
  logic                    isAddc;
  logic [7:0]              cmpFirst;
  logic [7:0]              cmpSecond;
  logic [7:0]              rmwByte;
  logic [7:0]              decSource;
  logic [7:0]              addSource;
  logic [4:0]              addLow;
  logic [8:0]              addFull;
  logic [7:0]              addLow7;
  logic [8:0]              daStep1;
  logic [8:0]              daStep2;
  logic                    daCarry1;
  logic [1:0]              instrLen;
  logic [15:0]             seqPc;
  logic [15:0]             relPc;

  // ****************************************
  // Decode and datapath terms
  // ****************************************
  always_comb begin
    op     = request.opcode;
    isCmp  = (op == cce_pkg::OP_CMP_A_IMM) || (op == cce_pkg::OP_CMP_A_DIR)
          || (op[7:1] == cce_pkg::OP_CMP_IND[7:1])
          || (op[7:3] == cce_pkg::OP_CMP_REG[7:3]);                      // see RL4
    isDec  = (op == cce_pkg::OP_DEC_A) || (op == cce_pkg::OP_DEC_DIR)
          || (op[7:1] == cce_pkg::OP_DEC_IND[7:1])
          || (op[7:3] == cce_pkg::OP_DEC_REG[7:3]);                      // see RL14
    isAdd  = (op[7:4] == cce_pkg::OP_ADD_IMM[7:4]) && (op[3:0] >= 4'h4);
    isAddc = (op[7:4] == cce_pkg::OP_ADDC_IMM[7:4]) && (op[3:0] >= 4'h4);

    // Accumulator pairings compare A, the others compare the fetched byte
    if ((op == cce_pkg::OP_CMP_A_IMM) || (op == cce_pkg::OP_CMP_A_DIR)) begin
      cmpFirst = request.acc;
    end else begin
      cmpFirst = request.opByte;
    end
    if (op == cce_pkg::OP_CMP_A_DIR) begin
      cmpSecond = request.opByte;
    end else begin
      cmpSecond = request.immData;
    end

    // Read-modify-write of a port uses the output latch
    if (request.byteIsPort) begin
      rmwByte = request.portLatch;                                        // see RL9
    end else begin
      rmwByte = request.opByte;
    end
    if (op == cce_pkg::OP_DEC_A) begin
      decSource = request.acc;
    end else begin
      decSource = rmwByte;
    end

    if ((op == cce_pkg::OP_ADD_IMM) || (op == cce_pkg::OP_ADDC_IMM)) begin
      addSource = request.immData;
    end else begin
      addSource = request.opByte;
    end

    // Binary add with the three carry taps
    addLow  = {1'b0, request.acc[3:0]} + {1'b0, addSource[3:0]}
            + {4'h0, isAddc & request.carry};                            // see RL17
    addLow7 = {1'b0, request.acc[6:0]} + {1'b0, addSource[6:0]}
            + {7'h00, isAddc & request.carry};
    addFull = {1'b0, request.acc} + {1'b0, addSource}
            + {8'h00, isAddc & request.carry};                           // see RL17

    // Decimal adjust in two stages, carry only ever set
    if ((request.acc[3:0] > cce_pkg::BCD_MAX_DIGIT) || request.auxCarry) begin
      daStep1 = {1'b0, request.acc} + cce_pkg::BCD_LOW_FIX;              // see RL10
    end else begin
      daStep1 = {1'b0, request.acc};
    end
    daCarry1 = request.carry | daStep1[8];                               // see RL10
    if ((daStep1[7:4] > cce_pkg::BCD_MAX_DIGIT) || daCarry1) begin
      daStep2 = {1'b0, daStep1[7:0]} + cce_pkg::BCD_HIGH_FIX;            // see RL11
    end else begin
      daStep2 = {1'b0, daStep1[7:0]};
    end

    // Instruction length for sequential program counter
    if (isCmp) begin
      instrLen = cce_pkg::LEN_THREE;                                      // see RL2
    end else if ((op == cce_pkg::OP_CLR_BIT) || (op == cce_pkg::OP_CPL_BIT)
              || (op == cce_pkg::OP_DEC_DIR) || (op == cce_pkg::OP_ADD_IMM)
              || (op == cce_pkg::OP_ADD_DIR) || (op == cce_pkg::OP_ADDC_IMM)
              || (op == cce_pkg::OP_ADDC_DIR)) begin
      instrLen = cce_pkg::LEN_TWO;
    end else begin
      instrLen = cce_pkg::LEN_ONE;
    end
    seqPc = request.pc + {14'h0000, instrLen};
    relPc = seqPc + {{8{request.rel[7]}}, request.rel};                  // see RL2
  end

  // ****************************************
  // Operation sequencing
  // ****************************************
  always_comb begin
    state_next  = state_reg;
    result_next = result_reg;
    done_next   = 1'b0;
    busy_next   = busy_reg;
    held_next   = held_reg;
    divStart    = 1'b0;
    case (state_reg)
      cce_pkg::ST_IDLE: begin
        if (start) begin
          result_next          = cce_pkg::RST_RESULT;
          result_next.carry    = request.carry;
          result_next.auxCarry = request.auxCarry;
          result_next.overflow = request.overflow;
          result_next.nextPc   = seqPc;
          done_next            = 1'b1;
          if (isCmp) begin
            result_next.pswWrite    = 1'b1;
            result_next.carry       = (cmpFirst < cmpSecond);             // see RL3
            result_next.branchTaken = (cmpFirst != cmpSecond);            // see RL1
            if (cmpFirst != cmpSecond) begin
              result_next.nextPc = relPc;                                 // see RL1
            end
          end else if (isDec) begin
            if (op == cce_pkg::OP_DEC_A) begin
              result_next.accWrite = 1'b1;
              result_next.accValue = decSource - cce_pkg::BYTE_ONE;       // see RL13
            end else begin
              result_next.byteWrite = 1'b1;
              result_next.byteValue = decSource - cce_pkg::BYTE_ONE;      // see RL13
            end
          end else if (isAdd || isAddc) begin
            result_next.accWrite = 1'b1;
            result_next.accValue = addFull[7:0];
            result_next.pswWrite = 1'b1;                                  // see RL18
            result_next.carry    = addFull[8];                            // see RL17
            result_next.auxCarry = addLow[4];                             // see RL17
            result_next.overflow = addFull[8] ^ addLow7[7];
          end else begin
            case (op)
              cce_pkg::OP_CLR_A: begin
                result_next.accWrite = 1'b1;
                result_next.accValue = cce_pkg::BYTE_ZERO;                // see RL5
              end
              cce_pkg::OP_CPL_A: begin
                result_next.accWrite = 1'b1;
                result_next.accValue = ~request.acc;                      // see RL7
              end
              cce_pkg::OP_CLR_C: begin
                result_next.pswWrite = 1'b1;
                result_next.carry    = 1'b0;                              // see RL6
              end
              cce_pkg::OP_CLR_BIT: begin
                result_next.bitWrite = 1'b1;
                result_next.bitValue = 1'b0;                              // see RL6
              end
              cce_pkg::OP_CPL_C: begin
                result_next.pswWrite = 1'b1;
                result_next.carry    = ~request.carry;                    // see RL8
              end
              cce_pkg::OP_CPL_BIT: begin
                result_next.bitWrite = 1'b1;
                result_next.bitValue = ~request.bitLatch;                 // see RL8, RL9
              end
              cce_pkg::OP_DEC_ADJ: begin
                result_next.accWrite = 1'b1;
                result_next.accValue = daStep2[7:0];                      // see RL12
                result_next.pswWrite = 1'b1;                              // see RL18
                result_next.carry    = daCarry1 | daStep2[8];             // see RL11
              end
              cce_pkg::OP_DIV: begin
                result_next.pswWrite = 1'b1;
                result_next.carry    = 1'b0;                              // see RL15, RL16
                if (request.auxReg == cce_pkg::BYTE_ZERO) begin
                  result_next.overflow = 1'b1;                            // see RL16
                end else begin
                  result_next.overflow = 1'b0;                            // see RL15
                  done_next            = 1'b0;
                  busy_next            = 1'b1;
                  held_next            = request;
                  divStart             = 1'b1;
                  state_next           = cce_pkg::ST_DIV;
                end
              end
              default: begin
                result_next.pswWrite = 1'b0;
              end
            endcase
          end
        end
      end
      cce_pkg::ST_DIV: begin
        if (divDone) begin
          result_next.accWrite = 1'b1;
          result_next.accValue = divQuotient;                             // see RL15
          result_next.auxWrite = 1'b1;
          result_next.auxValue = divRemainder;                            // see RL15
          done_next            = 1'b1;
          busy_next            = 1'b0;
          state_next           = cce_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = cce_pkg::ST_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg  <= cce_pkg::ST_IDLE;
      result_reg <= cce_pkg::RST_RESULT;
      done_reg   <= cce_pkg::RST_DONE;
      busy_reg   <= cce_pkg::RST_BUSY;
      held_reg   <= '0;
    end else begin
      state_reg  <= state_next;
      result_reg <= result_next;
      done_reg   <= done_next;
      busy_reg   <= busy_next;
      held_reg   <= held_next;
    end
  end

  // ****************************************
  // Divider
  // ****************************************
  cce_div_unit divider (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .start     (divStart),
    .dividend  (request.acc),
    .divisor   (held_reg.auxReg),
    .quotient  (divQuotient),
    .remainder (divRemainder),
    .done      (divDone)
  );

  assign result = result_reg;
  assign done   = done_reg;
  assign busy   = busy_reg;

endmodule

//--- cce_exec_properties.sv
// Port checker for the compare, clear, decimal adjust, decrement and divide unit.
// Assumes it is bound to cce_exec_unit and sees only that module's ports.
`timescale 1ns/10ps

module cce_exec_properties (
  input wire logic                     ref_clk,
  input wire logic                     rst,
  input wire logic                     start,
  input wire cce_pkg::cce_request_type request,
  input wire cce_pkg::cce_result_type  result,
  input wire logic                     done,
  input wire logic                     busy
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic take;
  assign take = start && !busy;

  // ****************************************
  // Sequences
  // ****************************************
  sequence div_iterate;
    busy [*8] ##1 busy;
  endsequence

  sequence div_finish;
    done && !busy && result.pswWrite && !result.carry && !result.overflow;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  a_div_latency_flags: assert property (
    take && request.opcode == cce_pkg::OP_DIV && request.auxReg != 8'h00
      |=> div_iterate ##1 div_finish) else $error("divide latency or flags wrong");
  a_single_cycle_done: assert property (
    take && !(request.opcode == cce_pkg::OP_DIV && request.auxReg != 8'h00) |=> done)
    else $error("single cycle op missed done");
  a_cmp_carry_branch: assert property (
    take && request.opcode == cce_pkg::OP_CMP_A_IMM |=> result.pswWrite
      && result.carry == ($past(request.acc) < $past(request.immData))
      && result.branchTaken == ($past(request.acc) != $past(request.immData)))
    else $error("compare carry or branch wrong");
  a_cmp_target_pc: assert property (
    take && request.opcode == cce_pkg::OP_CMP_A_IMM && request.acc != request.immData
      |=> result.nextPc == $past(request.pc) + 16'h0003
        + {{8{$past(request.rel[7])}}, $past(request.rel)})
    else $error("compare branch target wrong");
  a_clr_acc_zero: assert property (
    take && request.opcode == cce_pkg::OP_CLR_A
      |=> result.accWrite && result.accValue == 8'h00 && !result.pswWrite)
    else $error("clear accumulator wrong");
  a_cpl_acc_invert: assert property (
    take && request.opcode == cce_pkg::OP_CPL_A
      |=> result.accValue == ~$past(request.acc) && !result.pswWrite)
    else $error("complement accumulator wrong");
  a_dec_acc_wrap: assert property (
    take && request.opcode == cce_pkg::OP_DEC_A
      |=> result.accValue == $past(request.acc) - 8'h01 && !result.pswWrite)
    else $error("decrement accumulator wrong");
  a_div_zero_ovf: assert property (
    take && request.opcode == cce_pkg::OP_DIV && request.auxReg == 8'h00
      |=> result.pswWrite && result.overflow && !result.carry && !result.accWrite)
    else $error("zero divisor flags wrong");
  a_da_keep_flags: assert property (
    take && request.opcode == cce_pkg::OP_DEC_ADJ
      |=> result.overflow == $past(request.overflow) && (result.carry || !$past(request.carry)))
    else $error("decimal adjust flags wrong");
endmodule

bind cce_exec_unit cce_exec_properties cce_exec_properties_inst (
  .ref_clk (ref_clk),
  .rst     (rst),
  .start   (start),
  .request (request),
  .result  (result),
  .done    (done),
  .busy    (busy)
);

//--- cce_seq_model.sv
// Model of the instruction sequencer that hands requests to the execution unit.
// Assumes the caller runs its tasks from just after a rising clock edge.
`timescale 1ns/10ps

module cce_seq_model (
  input  wire logic                ref_clk,
  input  wire logic                busy,
  output logic                     start,
  output cce_pkg::cce_request_type request
);
  initial begin
    start = 1'b0;
    request = '0;
  end

  // One start pulse, only while the unit is idle
  task automatic issue(input cce_pkg::cce_request_type r);
    @(posedge ref_clk);
    while (busy) @(posedge ref_clk);
    start <= 1'b1;
    request <= r;
    @(posedge ref_clk);
    start <= 1'b0;
  endtask

  // Operands are no longer held once done is seen
  task automatic drop();
    @(posedge ref_clk);
    request <= ~request;
  endtask
endmodule

//--- compare_clear_bcd_divide_exec_tb.sv
// Self-checking testbench for the execution unit.
// Assumes cce_pkg, the design and the sequencer model are compiled first.
`timescale 1ns/10ps

`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch at %0t: %s", $time, msg); end end

module compare_clear_bcd_divide_exec_tb;
  logic                    ref_clk;
  logic                    rst;
  logic                    start;
  logic                    done;
  logic                    busy;
  cce_pkg::cce_request_type request;
  cce_pkg::cce_request_type rq;
  cce_pkg::cce_result_type  result;
  int                      err_total = 0;
  int                      checks = 0;

  cce_exec_unit cce_exec_unit_inst (.ref_clk(ref_clk), .rst(rst), .start(start),
    .request(request), .result(result), .done(done), .busy(busy));
  cce_seq_model cce_seq_model_inst (.ref_clk(ref_clk), .busy(busy), .start(start),
    .request(request));

  always #50 ref_clk = ~ref_clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic run();
    int n;
    n = 0;
    cce_seq_model_inst.issue(rq);
    #1;
    while (done !== 1'b1 && n < 15) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(done, 1'b1, "no done")
    cce_seq_model_inst.drop();
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_compare();
    logic [7:0] ops [4];
    logic [7:0] x;
    logic [7:0] y;
    ops = '{cce_pkg::OP_CMP_A_DIR, cce_pkg::OP_CMP_A_IMM, cce_pkg::OP_CMP_IND, 8'hBF};
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 3; k++) begin
        x = 8'h56;
        y = (k == 0) ? 8'h56 : ((k == 1) ? 8'h60 : 8'h34);
        rq = '0;
        rq.opcode = ops[i];
        rq.pc = 16'h1234;
        rq.rel = 8'hF0;
        rq.carry = (k != 1);
        rq.acc = (i < 2) ? x : ~x;
        rq.opByte = (i == 0) ? y : ((i == 1) ? ~y : x);
        rq.immData = (i == 0) ? ~y : y;
        run();
        `CHK(result.carry, (k == 1), "compare carry")
        `CHK(result.pswWrite, 1'b1, "compare flag write")
        `CHK(result.branchTaken, (k != 0), "compare branch")
        `CHK(result.nextPc, (k != 0) ? 16'h1227 : 16'h1237, "compare pc")
        `CHK(result.accWrite | result.byteWrite, 1'b0, "operand changed")
      end
    end
    $display("test compare done");
  endtask

  task automatic test_clear_cpl();
    rq = '0;
    rq.acc = 8'h5C;
    rq.carry = 1'b1;
    rq.overflow = 1'b1;
    rq.auxCarry = 1'b1;
    rq.bitLatch = 1'b0;
    rq.opcode = cce_pkg::OP_CLR_A;
    run();
    `CHK(result.accValue, 8'h00, "clear acc")
    rq.opcode = cce_pkg::OP_CPL_A;
    run();
    `CHK(result.accValue, 8'hA3, "complement acc")
    rq.opcode = cce_pkg::OP_CLR_BIT;
    run();
    `CHK({result.bitWrite, result.bitValue, result.carry}, 3'b101, "clear bit")
    rq.opcode = cce_pkg::OP_CPL_BIT;
    run();
    `CHK({result.bitWrite, result.bitValue, result.carry}, 3'b111, "complement bit")
    rq.opcode = cce_pkg::OP_CLR_C;
    run();
    `CHK({result.carry, result.overflow, result.auxCarry}, 3'b011, "clear carry")
    rq.opcode = cce_pkg::OP_CPL_C;
    rq.overflow = 1'b0;
    run();
    `CHK({result.carry, result.overflow, result.auxCarry}, 3'b001, "cpl carry")
    $display("test clear complement done");
  endtask

  task automatic test_bcd();
    logic [7:0] ain [6] = '{8'hBE, 8'hC9, 8'h09, 8'h56, 8'h9A, 8'h45};
    logic [7:0] aex [6] = '{8'h24, 8'h29, 8'h69, 8'h5C, 8'h00, 8'h45};
    logic [5:0] acIn = 6'b000100;
    logic [5:0] cIn = 6'b001000;
    logic [5:0] cEx = 6'b111010;
    for (int i = 0; i < 6; i++) begin
      rq = '0;
      rq.opcode = cce_pkg::OP_DEC_ADJ;
      rq.acc = ain[i];
      rq.auxCarry = acIn[5 - i];
      rq.carry = cIn[5 - i];
      rq.overflow = i[0];
      run();
      `CHK(result.accValue, aex[i], "adjust value")
      `CHK(result.carry, cEx[5 - i], "adjust carry")
      `CHK(result.overflow, i[0], "adjust overflow")
    end
    $display("test decimal adjust done");
  endtask

  task automatic test_dec();
    logic [7:0] ops [4];
    logic [7:0] vin [4] = '{8'h00, 8'h05, 8'h33, 8'h00};
    logic [7:0] vex [4] = '{8'hFF, 8'h04, 8'h7F, 8'hFF};
    ops = '{cce_pkg::OP_DEC_A, 8'h1B, cce_pkg::OP_DEC_DIR, 8'h17};
    for (int i = 0; i < 4; i++) begin
      rq = '0;
      rq.opcode = ops[i];
      rq.acc = vin[i];
      rq.opByte = vin[i];
      rq.byteIsPort = (i == 2);
      rq.portLatch = 8'h80;
      run();
      `CHK((i == 0) ? result.accValue : result.byteValue, vex[i], "decrement")
      `CHK(result.pswWrite, 1'b0, "decrement flags")
    end
    $display("test decrement done");
  endtask

  task automatic test_div();
    logic [7:0] a [5] = '{8'hFB, 8'h00, 8'hFF, 8'h07, 8'h55};
    logic [7:0] b [5] = '{8'h12, 8'h05, 8'h01, 8'h09, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rq = '0;
      rq.opcode = cce_pkg::OP_DIV;
      rq.acc = a[i];
      rq.auxReg = b[i];
      rq.carry = 1'b1;
      rq.overflow = (i == 4) ? 1'b0 : 1'b1;
      run();
      if (i < 4) begin
        `CHK({result.accValue, result.auxValue}, {a[i] / b[i], a[i] % b[i]}, "quotient")
      end
      `CHK({result.carry, result.overflow}, {1'b0, i == 4}, "divide flags")
    end
    $display("test divide done");
  endtask

  task automatic test_add();
    logic [7:0] ops [3];
    logic [7:0] a [3] = '{8'hC3, 8'h0F, 8'h56};
    logic [7:0] d [3] = '{8'hAA, 8'h01, 8'h67};
    logic [10:0] ex [3] = '{{8'h6D, 3'b101}, {8'h10, 3'b010}, {8'hBE, 3'b001}};
    ops = '{cce_pkg::OP_ADD_IMM, cce_pkg::OP_ADD_IMM, cce_pkg::OP_ADDC_IMM};
    for (int i = 0; i < 3; i++) begin
      rq = '0;
      rq.opcode = ops[i];
      rq.acc = a[i];
      rq.immData = d[i];
      rq.carry = (i == 2);
      run();
      `CHK({result.accValue, result.carry, result.auxCarry, result.overflow}, ex[i], "add")
    end
    $display("test add flags done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK({done, busy, result}, {2'b00, cce_pkg::RST_RESULT}, "reset state")
    $display("test reset done");
    test_compare();
    test_clear_cpl();
    test_bcd();
    test_dec();
    test_div();
    test_add();
    give_verdict();
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
